//--- design/pcc_top.sv
// Cycle counting block: time-stamp, reference, unhalted and non-sleep counts.
`timescale 1ns/100ps
module pcc_top
    import pcc_pkg::*;
#(
    parameter logic [2:0] BUS_CODE   = 3'h1,
    parameter logic [4:0] BASE_RATIO = 5'h0A,
    parameter logic [4:0] XE_RATIO   = 5'h0C
) (
    // Clock and reset.
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // Register port.
    input  wire pcc_req_t          i_req,
    output logic [PCC_DW-1:0]      o_rdata,
    // Processor state.
    input  wire pcc_thr_t          i_thr,
    input  wire logic              i_bus_clk_run,
    input  wire logic              i_sleep,
    input  wire logic              i_deep_sleep,
    input  wire logic              i_fixed_tick,
    input  wire logic              i_xe_enable,
    input  wire logic              i_halt_pending_sel,
    // Status.
    output logic [PCC_NPMC-1:0]    o_pmc_ovf,
    output logic                   o_pkg_power_save,
    output logic                   o_pmc_powered
);
    localparam int CW = PCC_DW;

    logic [CW-1:0]       tsc_r;
    logic [CW-1:0]       mperf_r;
    logic [CW-1:0]       fix2_r;
    logic [CW-1:0]       apict_r;
    logic [CW-1:0]       ctr_r  [PCC_NPMC];
    logic [CW-1:0]       cfg_r  [PCC_NPMC];
    logic [CW-1:0]       sel_r  [PCC_NPMC];
    logic [PCC_NPMC-1:0] ovf_r;
    logic [PCC_NPMC-1:0] inc;
    logic                all_halt;
    logic                any_run;
    logic                tsc_run;
    logic                rate_tick;
    logic [4:0]          ratio;

    // A thread counts as running only while not halted; power saving
    // requires every thread halted, so any runner keeps the package up.
    assign all_halt  = &i_thr.halted;
    assign any_run   = ~all_halt & ~i_sleep;
    assign tsc_run   = i_bus_clk_run & ~i_sleep & ~i_deep_sleep;
    assign ratio     = i_xe_enable ? XE_RATIO : BASE_RATIO;

    // The fixed tick already arrives at bus code times resolved ratio, so
    // the core frequency never enters the count; no local divider is kept.
    assign rate_tick = i_fixed_tick;

    function automatic logic thread_qual(input logic [CW-1:0] sel,
                                         input pcc_thr_t thr);
        logic q;
        q = 1'b0;
        if (!thr.halted[0])
            q = thr.user[0] ? sel[PCC_S_T0U] : sel[PCC_S_T0S];
        if (!thr.halted[1])
            q = q | (thr.user[1] ? sel[PCC_S_T1U] : sel[PCC_S_T1S]);
        return q;
    endfunction

    function automatic logic every_cycle(input logic [CW-1:0] cfg);
        return cfg[PCC_F_CMP] && cfg[PCC_F_CPL] &&
               cfg[PCC_F_THR_HI:PCC_F_THR_LO] == PCC_THR_ALL;
    endfunction

    genvar g;
    generate
        for (g = 0; g < PCC_NPMC; g++) begin : g_pmc
            logic has_ev;
            logic run_ev;
            assign has_ev = sel_r[g][PCC_S_EV_HI:PCC_S_EV_LO] != PCC_EV_NONE;
            assign run_ev = sel_r[g][PCC_S_EV_HI:PCC_S_EV_LO] == PCC_EV_POWER
                         && sel_r[g][PCC_S_MASK_LO + PCC_MASK_RUN];
            // Every-cycle mode skips qualifiers but still needs power.
            assign inc[g] = cfg_r[g][PCC_F_EN] && has_ev &&
                            (every_cycle(cfg_r[g]) ? any_run
                           : run_ev && (thread_qual(sel_r[g], i_thr) ||
                                        i_halt_pending_sel));

            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    ctr_r[g] <= '0;
                    ovf_r[g] <= 1'b0;
                end else begin
                    if (i_req.wr && i_req.addr == PCC_A_CTR0 + 8'(g))
                        ctr_r[g] <= i_req.wdata;
                    else if (inc[g])
                        ctr_r[g] <= ctr_r[g] + 1'b1;
                    // Overflow sets on the wrap and wins over a clear.
                    if (inc[g] && &ctr_r[g])
                        ovf_r[g] <= 1'b1;
                    else if (i_req.wr && i_req.addr == PCC_A_CFG0 + 8'(g)
                             && !i_req.wdata[PCC_F_OVF])
                        ovf_r[g] <= 1'b0;
                end
            end

            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    cfg_r[g] <= '0;
                    sel_r[g] <= '0;
                end else begin
                    if (i_req.wr && i_req.addr == PCC_A_CFG0 + 8'(g))
                        cfg_r[g] <= i_req.wdata;
                    if (i_req.wr && i_req.addr == PCC_A_SEL0 + 8'(g))
                        sel_r[g] <= i_req.wdata;
                end
            end
        end
    endgenerate

    // Time-stamp and fixed-rate counters.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tsc_r   <= '0;
            mperf_r <= '0;
            fix2_r  <= '0;
        end else begin
            if (i_req.wr && i_req.addr == PCC_A_TSC)
                tsc_r <= i_req.wdata;
            else if (tsc_run && rate_tick)
                tsc_r <= tsc_r + 1'b1;
            if (rate_tick && !all_halt) begin
                mperf_r <= mperf_r + 1'b1;
                fix2_r  <= fix2_r + 1'b1;
            end
        end
    end

    // Timer of the interrupt controller runs off the bus clock only.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            apict_r <= '0;
        else if (i_bus_clk_run)
            apict_r <= apict_r + 1'b1;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_pkg_power_save <= 1'b0;
            o_pmc_powered    <= 1'b1;
            o_pmc_ovf        <= '0;
        end else begin
            o_pkg_power_save <= all_halt;
            o_pmc_powered    <= ~all_halt;
            o_pmc_ovf        <= ovf_r;
        end
    end

    // Read data for the address of the strobe, one cycle later.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else if (i_req.rd) begin
            o_rdata <= '0;
            unique case (i_req.addr)
                PCC_A_BUSFREQ:
                    o_rdata[PCC_F_BF_HI:0] <= BUS_CODE;
                PCC_A_PLATID:
                    o_rdata[PCC_F_BR_HI:PCC_F_BR_LO] <= BASE_RATIO;
                PCC_A_PERFSTAT: begin
                    o_rdata[PCC_F_XR_HI:PCC_F_XR_LO] <= XE_RATIO;
                    o_rdata[PCC_F_XE] <= i_xe_enable;
                end
                PCC_A_TSC:      o_rdata <= tsc_r;
                PCC_A_MPERF:    o_rdata <= mperf_r;
                PCC_A_FIX2:     o_rdata <= fix2_r;
                PCC_A_APICT:    o_rdata <= apict_r;
                PCC_A_STAT:     o_rdata <= {{(CW-PCC_NPMC-5){1'b0}}, ratio,
                                            ovf_r};
                PCC_A_CTR0:     o_rdata <= ctr_r[0];
                PCC_A_CTR0 + 8'h01: o_rdata <= ctr_r[1];
                PCC_A_CFG0:     o_rdata <= {cfg_r[0][CW-1:PCC_F_OVF+1],
                                            ovf_r[0],
                                            cfg_r[0][PCC_F_OVF-1:0]};
                PCC_A_CFG0 + 8'h01: o_rdata <= {cfg_r[1][CW-1:PCC_F_OVF+1],
                                            ovf_r[1],
                                            cfg_r[1][PCC_F_OVF-1:0]};
                PCC_A_SEL0:     o_rdata <= sel_r[0];
                PCC_A_SEL0 + 8'h01: o_rdata <= sel_r[1];
                default:        o_rdata <= '0;
            endcase
        end
    end

    // Guards.
    every_cnt_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cfg_r[0][PCC_F_EN] && every_cycle(cfg_r[0]) &&
         sel_r[0][PCC_S_EV_HI:PCC_S_EV_LO] != PCC_EV_NONE && any_run &&
         !(i_req.wr && i_req.addr == PCC_A_CTR0))
        |=> ctr_r[0] == $past(ctr_r[0]) + 1'b1)
        else $error("every-cycle counter did not step");
    hold_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!cfg_r[0][PCC_F_EN] && !(i_req.wr && i_req.addr == PCC_A_CTR0))
        |=> $stable(ctr_r[0]))
        else $error("disabled counter moved");
    no_event_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        sel_r[1][PCC_S_EV_HI:PCC_S_EV_LO] == PCC_EV_NONE |-> !inc[1])
        else $error("counter with no event stepped");
    tsc_stop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ((i_sleep || i_deep_sleep || !i_bus_clk_run) &&
         !(i_req.wr && i_req.addr == PCC_A_TSC)) |=> $stable(tsc_r))
        else $error("time-stamp moved while asleep");
    powered_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !all_halt |=> o_pmc_powered && !o_pkg_power_save)
        else $error("counters powered down with a thread running");
    ovf_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (inc[0] && &ctr_r[0] && !(i_req.wr && i_req.addr == PCC_A_CTR0))
        |=> ctr_r[0] == '0 && ovf_r[0] ##1 o_pmc_ovf[0])
        else $error("wrap did not flag overflow");
    xe_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_req.rd && i_req.addr == PCC_A_PERFSTAT)
        |=> o_rdata[PCC_F_XE] == $past(i_xe_enable))
        else $error("extended bit misreported");
    busfreq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_req.rd && i_req.addr == PCC_A_BUSFREQ)
        |=> o_rdata[PCC_F_BF_HI:0] == BUS_CODE)
        else $error("bus frequency code wrong");
    ref_halt_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        all_halt |=> $stable(mperf_r))
        else $error("reference count moved while halted");
endmodule

//--- include/pcc_pkg.sv
// Package with register map, field layout and types of the cycle counter.
//
// Summary of operation
// - Unhalted count advances when the selected thread is running or i_halt_pending_sel is high.
// - Non-sleep count advances while the package is awake; not per thread.
// - Time-stamp count runs while bus clock runs and sleep pin is low.
// - Time-stamp count stops in deep sleep and resumes on leaving it.
// - Counters power down only when every thread is halted.
// - Performance counters flag overflow so sampling interrupts are possible.
// - Compare 1, threshold 15, complement 1 gives a count every cycle.
// - Every-cycle mode ignores thread and privilege qualifiers.
// - A counter whose selector names no event stays disabled.
// - A counter counts only with its enable bit set; else it holds.
// - Unhalted count may include cycles of the halt transition.
// - Non-sleep count runs while any thread is awake.
// - The package enters power saving only when all threads halt.
// - Reference-cycle event counts fixed-rate ticks while not halted.
// - Time-stamp count keeps a fixed rate across frequency changes.
// - Reference and third fixed counter step at the time-stamp rate.
// - Fixed rate is bus frequency code times maximum resolved ratio.
// - Interrupt controller timer is unaffected by frequency changes.
// - Bus frequency code reads from bits 2:0 at address 0CD.
// - Ratio comes from identity bits 12:8, or status 44:40 if extended.
// - Status bit 31 shows extended operation and ignores writes.
// - Threshold sits in bits 23:20, used only with compare set.
package pcc_pkg;
    localparam int          PCC_AW          = 8;
    localparam int          PCC_DW          = 64;
    localparam int          PCC_NTHR        = 2;
    localparam int          PCC_NPMC        = 2;
    // Register addresses.
    localparam logic [7:0]  PCC_A_BUSFREQ   = 8'hCD;
    localparam logic [7:0]  PCC_A_PLATID    = 8'h17;
    localparam logic [7:0]  PCC_A_PERFSTAT  = 8'h98;
    localparam logic [7:0]  PCC_A_TSC       = 8'h10;
    localparam logic [7:0]  PCC_A_MPERF     = 8'hE7;
    localparam logic [7:0]  PCC_A_FIX2      = 8'hE8;
    localparam logic [7:0]  PCC_A_APICT     = 8'hE9;
    localparam logic [7:0]  PCC_A_STAT      = 8'hEA;
    localparam logic [7:0]  PCC_A_CTR0      = 8'hC0;
    localparam logic [7:0]  PCC_A_CFG0      = 8'hD0;
    localparam logic [7:0]  PCC_A_SEL0      = 8'hD8;
    // Field positions.
    localparam int          PCC_F_EN        = 12;
    localparam int          PCC_F_CMP       = 18;
    localparam int          PCC_F_CPL       = 19;
    localparam int          PCC_F_THR_LO    = 20;
    localparam int          PCC_F_THR_HI    = 23;
    localparam int          PCC_F_OVF       = 31;
    localparam int          PCC_F_XE        = 31;
    localparam int          PCC_F_XR_LO     = 40;
    localparam int          PCC_F_XR_HI     = 44;
    localparam int          PCC_F_BR_LO     = 8;
    localparam int          PCC_F_BR_HI     = 12;
    localparam int          PCC_F_BF_HI     = 2;
    localparam int          PCC_S_EV_LO     = 25;
    localparam int          PCC_S_EV_HI     = 30;
    localparam int          PCC_S_MASK_LO   = 9;
    localparam int          PCC_S_T0U       = 2;
    localparam int          PCC_S_T0S       = 3;
    localparam int          PCC_S_T1U       = 0;
    localparam int          PCC_S_T1S       = 1;
    localparam logic [5:0]  PCC_EV_NONE     = 6'h00;
    localparam logic [5:0]  PCC_EV_POWER    = 6'h13;
    localparam int          PCC_MASK_RUN    = 0;
    localparam logic [3:0]  PCC_THR_ALL     = 4'hF;
    localparam logic [7:0]  PCC_RATE_W      = 8'h08;

    typedef struct packed {
        logic [PCC_AW-1:0] addr;
        logic [PCC_DW-1:0] wdata;
        logic              wr;
        logic              rd;
    } pcc_req_t;

    typedef struct packed {
        logic [PCC_NTHR-1:0] halted;
        logic [PCC_NTHR-1:0] user;
    } pcc_thr_t;
endpackage

//--- test/tb_top.sv
// Self-checking testbench for the processor cycle counting block.
`timescale 1ns/100ps
module tb_top;
    import pcc_pkg::*;
    localparam logic [2:0] BC = 3'h5;
    localparam logic [4:0] BR = 5'h0B;
    localparam logic [4:0] XR = 5'h13;
    typedef struct {
        logic [63:0] exp;
        logic [63:0] mask;
        bit          nz;
    } pcc_note_t;
    logic                i_clk;
    logic                i_rst_n;
    pcc_req_t            i_req;
    logic [PCC_DW-1:0]   o_rdata;
    pcc_thr_t            i_thr;
    logic                i_bus_clk_run;
    logic                i_sleep;
    logic                i_deep_sleep;
    logic                i_fixed_tick;
    logic                i_xe_enable;
    logic                i_halt_pending_sel;
    logic [PCC_NPMC-1:0] o_pmc_ovf;
    logic                o_pkg_power_save;
    logic                o_pmc_powered;
    pcc_note_t           notes[$];
    pcc_note_t           nt;
    logic                rd_q = 1'b0;
    int                  err_count = 0;
    int                  checks = 0;
    int                  n;
    logic [63:0]         timestamp_counter, mref, sel, cyc, en;

    pcc_top #(.BUS_CODE(BC), .BASE_RATIO(BR), .XE_RATIO(XR)) dut_u (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req), .o_rdata(o_rdata),
        .i_thr(i_thr), .i_bus_clk_run(i_bus_clk_run), .i_sleep(i_sleep),
        .i_deep_sleep(i_deep_sleep), .i_fixed_tick(i_fixed_tick),
        .i_xe_enable(i_xe_enable), .i_halt_pending_sel(i_halt_pending_sel),
        .o_pmc_ovf(o_pmc_ovf), .o_pkg_power_save(o_pkg_power_save),
        .o_pmc_powered(o_pmc_powered));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [63:0] d);
        @(posedge i_clk);
        i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask

    // A note is queued at issue; the monitor pops it when the data stands.
    task automatic rd(input logic [7:0] a, input logic [63:0] e,
                      input logic [63:0] m, input bit z = 1'b0);
        @(posedge i_clk);
        i_req <= '{addr: a, wdata: 64'h0, wr: 1'b0, rd: 1'b1};
        notes.push_back('{e, m, z});
    endtask

    task automatic idle(input int c);
        repeat (c) begin
            @(posedge i_clk);
            i_req <= '0;
        end
    endtask

    task automatic ticks(input int c);
        repeat (c) begin
            @(posedge i_clk);
            i_req <= '0;
            i_fixed_tick <= 1'b1;
            @(posedge i_clk);
            i_fixed_tick <= 1'b0;
        end
    endtask

    always @(posedge i_clk) begin
        rd_q <= i_req.rd;
        if (rd_q && notes.size() > 0) begin
            nt = notes.pop_front();
            if (nt.nz) begin
                check(64'(|(o_rdata & nt.mask)), 64'h1);
            end else begin
                check(o_rdata & nt.mask, nt.exp & nt.mask);
            end
        end
    end

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        #(20000 * 8);
        err_count++;
        summarize();
    end

    initial begin
        i_rst_n = 1'b0;
        i_req = '0;
        i_thr = '{halted: 2'b00, user: 2'b11};
        i_bus_clk_run = 1'b1;
        i_sleep = 1'b0;
        i_deep_sleep = 1'b0;
        i_fixed_tick = 1'b0;
        i_xe_enable = 1'b0;
        i_halt_pending_sel = 1'b0;
        void'($urandom(32'h55CB9D9C));
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(PCC_A_BUSFREQ, 64'(BC), 64'h7);
        rd(PCC_A_PLATID, 64'(BR) << 8, 64'h1F00);
        rd(PCC_A_PERFSTAT, 64'h0, 64'h8000_0000);
        rd(PCC_A_STAT, 64'(BR) << 2, 64'h7F);
        rd(8'h55, 64'h0, '1);
        rd(PCC_A_TSC, 64'h0, '1);
        wr(PCC_A_BUSFREQ, '1);
        rd(PCC_A_BUSFREQ, 64'(BC), 64'h7);
        i_xe_enable <= 1'b1;
        idle(3);
        wr(PCC_A_PERFSTAT, 64'h0);
        rd(PCC_A_PERFSTAT, (64'(XR) << 40) | (64'h1 << 31),
           64'h0000_1F00_8000_0000);
        rd(PCC_A_STAT, 64'(XR) << 2, 64'h7C);
        rd(PCC_A_APICT, 64'h0, '1, 1'b1);
        idle(3);
        $display("test registers done");
        n = $urandom_range(8, 1);
        ticks(n);
        timestamp_counter = 64'(n);
        mref = 64'(n);
        idle(2);
        rd(PCC_A_TSC, timestamp_counter, '1);
        rd(PCC_A_MPERF, mref, '1);
        rd(PCC_A_FIX2, mref, '1);
        i_thr.halted <= 2'b11;
        idle(3);
        #1 check(64'(o_pkg_power_save), 64'h1);
        check(64'(o_pmc_powered), 64'h0);
        n = $urandom_range(8, 1);
        ticks(n);
        timestamp_counter += 64'(n);
        idle(2);
        rd(PCC_A_TSC, timestamp_counter, '1);
        rd(PCC_A_MPERF, mref, '1);
        i_thr.halted <= 2'b01;
        idle(3);
        #1 check(64'(o_pkg_power_save), 64'h0);
        check(64'(o_pmc_powered), 64'h1);
        for (int k = 0; k < 3; k++) begin
            i_bus_clk_run <= (k != 0);
            i_sleep <= (k == 1);
            i_deep_sleep <= (k == 2);
            ticks($urandom_range(6, 1));
            i_bus_clk_run <= 1'b1;
            i_sleep <= 1'b0;
            i_deep_sleep <= 1'b0;
            n = $urandom_range(6, 1);
            ticks(n);
            timestamp_counter += 64'(n);
            idle(2);
            rd(PCC_A_TSC, timestamp_counter, '1);
        end
        idle(3);
        $display("test time-stamp done");
        // The tick is held high so either counting clock steps every cycle.
        i_fixed_tick <= 1'b1;
        i_thr <= '{halted: 2'b00, user: 2'b10};
        sel = (64'(PCC_EV_POWER) << PCC_S_EV_LO)
            | (64'h1 << (PCC_S_MASK_LO + PCC_MASK_RUN));
        cyc = (64'h1 << PCC_F_CMP) | (64'h1 << PCC_F_CPL)
            | (64'(PCC_THR_ALL) << PCC_F_THR_LO);
        en = 64'h1 << PCC_F_EN;
        wr(PCC_A_SEL0, sel);
        wr(PCC_A_SEL0 + 8'h01, 64'(PCC_EV_NONE) << PCC_S_EV_LO);
        wr(PCC_A_CFG0, cyc);
        wr(PCC_A_CFG0 + 8'h01, cyc | en);
        idle(10);
        rd(PCC_A_CTR0, 64'h0, '1);
        rd(PCC_A_CTR0 + 8'h01, 64'h0, '1);
        wr(PCC_A_CFG0, cyc | en);
        idle(10);
        rd(PCC_A_CTR0, 64'h0, '1, 1'b1);
        wr(PCC_A_CFG0 + 8'h01, 64'h0);
        wr(PCC_A_SEL0 + 8'h01, sel | (64'h3 << PCC_S_T0U));
        i_thr.halted <= 2'b01;
        wr(PCC_A_CFG0 + 8'h01, en);
        idle(10);
        rd(PCC_A_CTR0 + 8'h01, 64'h0, '1);
        i_halt_pending_sel <= 1'b1;
        idle(10);
        rd(PCC_A_CTR0 + 8'h01, 64'h0, '1, 1'b1);
        i_halt_pending_sel <= 1'b0;
        i_thr.halted <= 2'b00;
        idle(10);
        rd(PCC_A_CTR0 + 8'h01, 64'h0, '1, 1'b1);
        idle(4);
        check(64'(o_pmc_ovf), 64'h0);
        wr(PCC_A_CTR0, 64'hFFFF_FFFF_FFFF_FFFD);
        idle(8);
        check(64'(o_pmc_ovf), 64'h1);
        rd(PCC_A_CFG0, 64'h1 << PCC_F_OVF, 64'h1 << PCC_F_OVF);
        wr(PCC_A_CFG0, cyc | en);
        idle(4);
        check(64'(o_pmc_ovf), 64'h0);
        $display("test counters done");
        summarize();
    end
endmodule
